// [rtl/prs_readout.sv]
// Training pattern store read path: mode entry, read decode, latency and lane formats
`timescale 1ns/1ns
`default_nettype none
`include "prs_consts.svh"
module prs_readout #(
  parameter int DQ_W      = 16,
  parameter int AL_CYC    = 0,
  parameter int CL_CYC    = 11,
  parameter int MOD_CYC   = 24,
  parameter int CCD_L_CYC = 6
) (
  // Clocks and reset
  input  wire logic              ref_clk,
  input  wire logic              lnk_clk,
  input  wire logic              rst,
  // Command and address from the controller, link clock
  input  wire prs_pkg::prs_cmd_t cmd,
  // Page 0 write port, ref clock
  input  wire logic              pg0_wr_vld,
  input  wire logic [1:0]        pg0_wr_loc,
  input  wire logic [7:0]        pg0_wr_data,
  // Read-only pages 1 to 3, ref clock
  input  wire prs_pkg::prs_ro_t  ro_pages,
  // Data lanes, rising and falling beat of each link cycle
  output logic [DQ_W-1:0]        dq_rise,
  output logic [DQ_W-1:0]        dq_fall,
  output logic                   dq_oe,
  // Strobe
  output logic                   dqs_run,
  output logic                   dqs_oe,
  // Inversion pin
  output logic                   dbi_oe,
  // Status, link clock
  output logic                   mode_on,
  output logic                   array_rd,
  output logic                   rd_err,
  // Status, ref clock
  output logic                   mode_on_ref
);
  import prs_pkg::*;

  localparam int RL = AL_CYC + CL_CYC;
  localparam logic [127:0] STORE_INIT = {96'h0, `PRS_PG0_DEF};
  localparam logic [3:0] CCD_L = 4'(CCD_L_CYC);
  localparam logic [$clog2(MOD_CYC+1)-1:0] MOD_LAST = ($clog2(MOD_CYC+1))'(MOD_CYC - 1);

  // Ref domain: page 0 contents
  prs_page_t  pg0_ff;
  prs_store_t snap_ref;
  prs_store_t store;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pg0_ff <= `PRS_PG0_DEF;
    else if (pg0_wr_vld)
      pg0_ff[pg0_wr_loc] <= pg0_wr_data;
  end

  // Only page 0 has a write path; pages 1 to 3 are driven from outside
  assign snap_ref = {ro_pages, pg0_ff};

  prs_word_xfer #(.W(128), .INIT(STORE_INIT)) u_store_xfer (
    .src_clk  (ref_clk),
    .dst_clk  (lnk_clk),
    .rst      (rst),
    .src_data (snap_ref),
    .dst_data (store)
  );

  // Link domain: mode register shadows
  logic [1:0] mr0_bl_ff;
  logic       rpre2_ff;

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      mr0_bl_ff <= '0;
      rpre2_ff  <= 1'b0;
    end
    else if (cmd.mrs && cmd.mr_sel == `PRS_MR0)
      mr0_bl_ff <= cmd.addr[`PRS_MR0_BL_RNG];
    else if (cmd.mrs && cmd.mr_sel == `PRS_MR4)
      rpre2_ff <= cmd.addr[`PRS_MR4_RPRE];
  end

  // Mode state machine
  prs_mode_t                      mode_ff;
  logic [$clog2(MOD_CYC+1)-1:0]   mod_cnt_ff;
  logic [1:0]                     page_ff;
  prs_fmt_t                       fmt_ff;
  logic                           mr3_wr;

  assign mr3_wr = cmd.mrs && cmd.mr_sel == `PRS_MR3;

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff    <= PRS_OFF;
      mod_cnt_ff <= '0;
      page_ff    <= `PRS_PAGE0;
      fmt_ff     <= PRS_FMT_SERIAL;
    end
    else
    begin
      case (mode_ff)
        PRS_OFF, PRS_ON:
        begin
          if (mr3_wr)
          begin
            mod_cnt_ff <= MOD_LAST;
            if (cmd.addr[`PRS_MR3_EN])
            begin
              page_ff <= cmd.addr[`PRS_MR3_PG_RNG];
              fmt_ff  <= prs_fmt_t'(cmd.addr[`PRS_MR3_FMT_RNG]);
              mode_ff <= PRS_ENTER;
            end
            else if (mode_ff == PRS_ON)
              mode_ff <= PRS_LEAVE;
          end
        end
        PRS_ENTER:
        begin
          if (mod_cnt_ff == '0)
            mode_ff <= PRS_ON;
          else
            mod_cnt_ff <= mod_cnt_ff - 1'b1;
        end
        PRS_LEAVE:
        begin
          if (mod_cnt_ff == '0)
            mode_ff <= PRS_OFF;
          else
            mod_cnt_ff <= mod_cnt_ff - 1'b1;
        end
        default:
          mode_ff <= PRS_OFF;
      endcase
    end
  end

  // Read decode
  logic       pat_rd;
  logic       chop;
  logic [3:0] gap_ff;
  logic       bad_rd;
  prs_rdreq_t new_req;

  assign pat_rd = cmd.rd && mode_ff == PRS_ON;
  // Fixed chop only; on-the-fly with the chop bit high reads as eight beats
  assign chop = mr0_bl_ff == `PRS_BL_BC4;

  always_comb
  begin
    new_req      = '0;
    new_req.vld  = pat_rd;
    new_req.chop = chop;
    new_req.half = chop & cmd.addr[`PRS_A_ORDER];
    new_req.loc  = cmd.ba;
    new_req.page = page_ff;
    new_req.fmt  = fmt_ff;
  end

  // Flag reads the controller should not have issued
  always_comb
  begin
    bad_rd = 1'b0;
    if (cmd.addr[`PRS_A_NIB_RNG] != `PRS_NIB_ZERO)
      bad_rd = 1'b1;
    else if (!chop && cmd.addr[`PRS_A_ORDER])
      bad_rd = 1'b1;
    else if (mr0_bl_ff == `PRS_BL_OTF && !cmd.addr[`PRS_A_CHOP])
      bad_rd = 1'b1;
    else if (fmt_ff == PRS_FMT_PARALLEL && cmd.ba != `PRS_LOC0)
      bad_rd = 1'b1;
    else if (fmt_ff == PRS_FMT_RSVD)
      bad_rd = 1'b1;
    else if (page_ff != `PRS_PAGE0 && gap_ff < CCD_L)
      bad_rd = 1'b1;
    else if (gap_ff < 4'(`PRS_CCD_S))
      bad_rd = 1'b1;
  end

  // Cycles since the last pattern read, saturating
  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
      gap_ff <= '1;
    else if (pat_rd)
      gap_ff <= 4'd1;
    else if (gap_ff != '1)
      gap_ff <= gap_ff + 1'b1;
  end

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      array_rd <= 1'b0;
      rd_err   <= 1'b0;
      mode_on  <= 1'b0;
    end
    else
    begin
      array_rd <= cmd.rd && mode_ff != PRS_ON;
      rd_err   <= pat_rd && bad_rd;
      mode_on  <= mode_ff == PRS_ON;
    end
  end

  // Read latency pipe
  prs_rdreq_t pipe_ff [RL];

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < RL; i++)
        pipe_ff[i] <= '0;
    end
    else
    begin
      pipe_ff[0] <= new_req;
      for (int i = 1; i < RL; i++)
        pipe_ff[i] <= pipe_ff[i-1];
    end
  end

  // Burst sequencer: a new read at the pipe tail overrides the running burst
  prs_rdreq_t cur_ff;
  logic [1:0] pair_ff;
  logic       busy_ff;
  prs_rdreq_t sel_req;
  logic [1:0] sel_pair;
  logic       sel_act;
  logic       sel_oe;
  logic [2:0] beat0;
  logic [2:0] beat1;
  logic       pre;

  always_comb
  begin
    sel_req  = cur_ff;
    sel_pair = '0;
    sel_act  = 1'b0;
    if (pipe_ff[RL-1].vld)
    begin
      sel_req = pipe_ff[RL-1];
      sel_act = 1'b1;
    end
    else if (busy_ff && pair_ff != `PRS_LAST_PAIR)
    begin
      sel_pair = pair_ff + 1'b1;
      sel_act  = 1'b1;
    end
  end

  // Chopped bursts leave the last four beats undriven
  assign sel_oe = sel_act && (!sel_req.chop || sel_pair < `PRS_BC4_PAIRS);
  assign beat0  = {sel_pair, 1'b0} + (sel_req.half ? `PRS_HALF_BEAT : 3'd0);
  assign beat1  = {sel_pair, 1'b1} + (sel_req.half ? `PRS_HALF_BEAT : 3'd0);
  assign pre    = pipe_ff[RL-2].vld || (rpre2_ff && pipe_ff[RL-3].vld);

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff  <= '0;
      pair_ff <= '0;
      busy_ff <= 1'b0;
    end
    else
    begin
      cur_ff  <= sel_req;
      pair_ff <= sel_pair;
      busy_ff <= sel_act;
    end
  end

  // One lane's bit for one beat
  function automatic logic lane_bit(
    input prs_store_t st,
    input prs_rdreq_t r,
    input logic [2:0] beat,
    input logic [2:0] lane
  );
    logic [1:0] sloc;
    sloc = r.loc + lane[1:0];
    case (r.fmt)
      PRS_FMT_PARALLEL:
        lane_bit = st[r.page][`PRS_LOC0][`PRS_BYTE_MSB - lane];
      PRS_FMT_STAGGER:
        lane_bit = st[r.page][sloc][`PRS_BYTE_MSB - beat];
      default:
        lane_bit = st[r.page][r.loc][`PRS_BYTE_MSB - beat];
    endcase
  endfunction

  logic [DQ_W-1:0] nxt_rise;
  logic [DQ_W-1:0] nxt_fall;

  // Lane index wraps every eight lanes, so x16 repeats the byte
  for (genvar k = 0; k < DQ_W; k++)
  begin : g_lane
    assign nxt_rise[k] = lane_bit(store, sel_req, beat0, 3'(k));
    assign nxt_fall[k] = lane_bit(store, sel_req, beat1, 3'(k));
  end

  always_ff @(posedge lnk_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_rise <= '0;
      dq_fall <= '0;
      dq_oe   <= 1'b0;
      dqs_run <= 1'b0;
      dqs_oe  <= 1'b0;
      dbi_oe  <= 1'b0;
    end
    else
    begin
      dq_rise <= sel_oe ? nxt_rise : '0;
      dq_fall <= sel_oe ? nxt_fall : '0;
      dq_oe   <= sel_oe;
      dqs_run <= sel_oe;
      dqs_oe  <= sel_oe || pre;
      // Pattern reads never invert, whatever the read inversion enable holds
      dbi_oe  <= 1'b0;
    end
  end

  prs_sync2 #(.W(1)) u_mode_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (mode_on),
    .q   (mode_on_ref)
  );

endmodule
`default_nettype wire

// [rtl/prs_consts.svh]
// Constant names for the training pattern store readout block
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Mode register selects on the command port
`define PRS_MR0          3'd0
`define PRS_MR3          3'd3
`define PRS_MR4          3'd4

// Mode register field positions
`define PRS_MR3_EN       2
`define PRS_MR3_FMT_RNG  12:11
`define PRS_MR3_PG_RNG   1:0
`define PRS_MR0_BL_RNG   1:0
`define PRS_MR4_RPRE     11

// Burst length encodings of mode register 0
`define PRS_BL_OTF       2'b01
`define PRS_BL_BC4       2'b10

// Read address fields
`define PRS_A_ORDER      2
`define PRS_A_CHOP       12
`define PRS_A_NIB_RNG    1:0
`define PRS_NIB_ZERO     2'b00

// Page and location constants
`define PRS_PAGE0        2'd0
`define PRS_LOC0         2'd0
`define PRS_PG0_DEF      32'h000f3355
`define PRS_BYTE_MSB     3'd7
`define PRS_HALF_BEAT    3'd4

// Burst shape: four beat pairs, chopped bursts drive two of them
`define PRS_LAST_PAIR    2'd3
`define PRS_BC4_PAIRS    2'd2
`define PRS_CCD_S        4

`endif

// [rtl/prs_pkg.sv]
// Types shared by the training pattern store readout block
package prs_pkg;

  typedef enum logic [1:0] {
    PRS_FMT_SERIAL,
    PRS_FMT_PARALLEL,
    PRS_FMT_STAGGER,
    PRS_FMT_RSVD
  } prs_fmt_t;

  typedef enum {
    PRS_OFF,
    PRS_ENTER,
    PRS_ON,
    PRS_LEAVE
  } prs_mode_t;

  typedef logic [7:0] prs_byte_t;
  typedef prs_byte_t [3:0] prs_page_t;
  typedef prs_page_t [3:0] prs_store_t;
  typedef prs_page_t [2:0] prs_ro_t;

  typedef struct packed {
    logic        mrs;
    logic        rd;
    logic [2:0]  mr_sel;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
  } prs_cmd_t;

  typedef struct packed {
    logic       vld;
    logic       chop;
    logic       half;
    logic [1:0] loc;
    logic [1:0] page;
    prs_fmt_t   fmt;
  } prs_rdreq_t;

endpackage

// [rtl/prs_sync2.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module prs_sync2 #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// [rtl/prs_word_xfer.sv]
// Toggle handshake that keeps a word snapshot current in another clock domain
`timescale 1ns/1ns
`default_nettype none
module prs_word_xfer #(
  parameter int           W    = 8,
  parameter logic [W-1:0] INIT = '0
) (
  // Clocks and reset
  input  wire logic         src_clk,
  input  wire logic         dst_clk,
  input  wire logic         rst,
  // Word in the source domain, copy in the destination domain
  input  wire logic [W-1:0] src_data,
  output logic      [W-1:0] dst_data
);
  logic         req_ff;
  logic [W-1:0] hold_ff;
  logic         ack_src;
  logic         req_dst;
  logic         seen_ff;
  logic [W-1:0] dst_ff;

  // Hold stays still while a request is open, so the wide copy is safe
  always_ff @(posedge src_clk or posedge rst)
  begin
    if (rst)
    begin
      req_ff  <= 1'b0;
      hold_ff <= INIT;
    end
    else if (ack_src == req_ff)
    begin
      req_ff  <= ~req_ff;
      hold_ff <= src_data;
    end
  end

  prs_sync2 #(.W(1)) u_req_sync (
    .clk (dst_clk),
    .rst (rst),
    .d   (req_ff),
    .q   (req_dst)
  );

  always_ff @(posedge dst_clk or posedge rst)
  begin
    if (rst)
    begin
      seen_ff <= 1'b0;
      dst_ff  <= INIT;
    end
    else if (req_dst != seen_ff)
    begin
      seen_ff <= req_dst;
      dst_ff  <= hold_ff;
    end
  end

  prs_sync2 #(.W(1)) u_ack_sync (
    .clk (src_clk),
    .rst (rst),
    .d   (seen_ff),
    .q   (ack_src)
  );

  assign dst_data = dst_ff;
endmodule
`default_nettype wire

// [dv/prs_ctl_model.sv]
// Controller model that drives the command port on the link clock
`timescale 1ns/1ns
`default_nettype none
module prs_ctl_model (
  // Link clock
  input  wire logic              lnk_clk,
  // Command to the device
  output var prs_pkg::prs_cmd_t  cmd
);
  import prs_pkg::*;
  initial cmd = '0;
  // Idle fields flip so a stale address never looks like a held command
  task automatic send(input logic rd, input logic [2:0] sel, input logic [1:0] ba,
                      input logic [17:0] a);
    @(posedge lnk_clk);
    cmd <= '{mrs: !rd, rd: rd, mr_sel: sel, bg: ~cmd.bg, ba: ba, addr: a};
    @(posedge lnk_clk);
    cmd <= '{mrs: 1'b0, rd: 1'b0, mr_sel: ~sel, bg: ~cmd.bg, ba: ~ba, addr: ~a};
  endtask
endmodule
`default_nettype wire

// [dv/prs_readout_chk.sv]
// Assertions on the link side ports of the pattern store readout
`timescale 1ns/1ns
`default_nettype none
module prs_readout_chk #(
  parameter int AL_CYC  = 0,
  parameter int CL_CYC  = 11,
  parameter int MOD_CYC = 24
) (
  // Link clock and reset
  input wire logic              lnk_clk,
  input wire logic              rst,
  // Command and link outputs
  input wire prs_pkg::prs_cmd_t cmd,
  input wire logic              dq_oe,
  input wire logic              dqs_oe,
  input wire logic              dqs_run,
  input wire logic              dbi_oe,
  input wire logic              mode_on,
  input wire logic              array_rd,
  input wire logic              rd_err
);
  import prs_pkg::*;
  localparam int RL   = AL_CYC + CL_CYC;
  localparam int MOD1 = MOD_CYC + 1;
  logic bc4_ff;
  default clocking @(posedge lnk_clk); endclocking
  default disable iff (rst);
  // Fixed chop is remembered from the last burst length write
  always_ff @(posedge lnk_clk or posedge rst)
    if (rst)
      bc4_ff <= 1'b0;
    else if (cmd.mrs && cmd.mr_sel == 3'h0)
      bc4_ff <= cmd.addr[1:0] == 2'h2;
  a_dbi_idle: assert property (!dbi_oe)
    else $error("inversion pin driven");
  a_strobe_data: assert property (dq_oe |-> dqs_oe && dqs_run)
    else $error("data without toggling strobe");
  a_array_redirect: assert property (cmd.rd && !mode_on |=> array_rd)
    else $error("read outside mode not sent to array");
  a_read_served: assert property (cmd.rd && mode_on && !$past(cmd.mrs) |=> !array_rd)
    else $error("read in mode sent to array");
  a_read_latency: assert property (cmd.rd && mode_on && !$past(cmd.mrs)
    |-> ##RL dqs_oe ##1 dq_oe)
    else $error("read data latency wrong");
  a_nib_start: assert property (cmd.rd && mode_on && cmd.addr[1:0] != 2'h0 |=> rd_err)
    else $error("bad nibble start not flagged");
  a_mode_exit: assert property (cmd.mrs && cmd.mr_sel == 3'h3 && !cmd.addr[2]
    |-> ##2 !mode_on)
    else $error("mode still on after exit");
  a_mode_entry: assert property (cmd.mrs && cmd.mr_sel == 3'h3 && cmd.addr[2]
    && !mode_on |=> !mode_on ##MOD1 mode_on)
    else $error("mode entry delay wrong");
  a_burst_len: assert property ($rose(dq_oe)
    |-> dq_oe[*2] ##1 (bc4_ff ? !dq_oe : dq_oe))
    else $error("burst length wrong");
endmodule
bind prs_readout prs_readout_chk #(
  .AL_CYC(AL_CYC), .CL_CYC(CL_CYC), .MOD_CYC(MOD_CYC)
) u_prs_readout_chk (
  .lnk_clk(lnk_clk), .rst(rst), .cmd(cmd), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
  .dqs_run(dqs_run), .dbi_oe(dbi_oe), .mode_on(mode_on), .array_rd(array_rd), .rd_err(rd_err)
);
`default_nettype wire

// [dv/prs_readout_bench.sv]
// Self-checking bench for the pattern store readout
`timescale 1ns/1ns
`default_nettype none
module prs_readout_bench;
  import prs_pkg::*;
  localparam int RL   = 5;
  localparam int MODC = 2;
  logic        ref_clk;
  logic        lnk_clk;
  logic        rst;
  prs_cmd_t    cmd;
  logic        pg0_wr_vld;
  logic [1:0]  pg0_wr_loc;
  logic [7:0]  pg0_wr_data;
  prs_ro_t     ro_pages;
  logic [15:0] dq_rise;
  logic [15:0] dq_fall;
  logic        dq_oe;
  logic        dqs_run;
  logic        dqs_oe;
  logic        dbi_oe;
  logic        mode_on;
  logic        array_rd;
  logic        rd_err;
  logic        mode_on_ref;
  prs_byte_t   pg0_ref [4];
  int          error_cnt;
  int          checked;
  int          n;
  // Rows: format, page, bank, A2, burst length field; register pages stay serial
  logic [8:0]  rows [10] = '{9'h008, 9'h018, 9'h030, 9'h080, 9'h108, 9'h118, 9'h058, 9'h062,
                             9'h006, 9'h011};
  prs_readout #(.DQ_W(16), .AL_CYC(0), .CL_CYC(RL), .MOD_CYC(MODC), .CCD_L_CYC(6)) u_prs_readout (
    .ref_clk(ref_clk), .lnk_clk(lnk_clk), .rst(rst), .cmd(cmd), .pg0_wr_vld(pg0_wr_vld),
    .pg0_wr_loc(pg0_wr_loc), .pg0_wr_data(pg0_wr_data), .ro_pages(ro_pages),
    .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe(dq_oe), .dqs_run(dqs_run), .dqs_oe(dqs_oe),
    .dbi_oe(dbi_oe), .mode_on(mode_on), .array_rd(array_rd), .rd_err(rd_err),
    .mode_on_ref(mode_on_ref));
  prs_ctl_model u_prs_ctl_model (.lnk_clk(lnk_clk), .cmd(cmd));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Link clock is offset, but its rising edges all land on ref clock edges, every other one on a ref rising edge; only its falling edges never line up
  initial
  begin
    lnk_clk = 1'b0;
    #3;
    forever
    begin
      #7 lnk_clk = 1'b1;
      #8 lnk_clk = 1'b0;
    end
  end
  function automatic prs_byte_t byte_of(logic [1:0] pg, logic [1:0] loc);
    return (pg == 2'h0) ? pg0_ref[loc] : ro_pages[pg - 2'h1][loc];
  endfunction
  function automatic logic [15:0] lanes(logic [8:0] r, int beat);
    logic [15:0] v;
    prs_byte_t   b;
    for (int k = 0; k < 16; k++)
    begin
      b = byte_of(r[6:5], (r[8:7] == 2'h1) ? 2'h0 : r[4:3] + ((r[8:7] == 2'h2) ? k[1:0] : 2'h0));
      v[k] = (r[8:7] == 2'h1) ? b[7 - (k % 8)] : b[7 - beat];
    end
    return v;
  endfunction
  task automatic chk_bit(logic got, logic exp, string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s is %b", $time, what, got);
    end
  endtask
  task automatic chk_pair(logic [15:0] er, logic [15:0] ef);
    checked++;
    if (dq_rise !== er || dq_fall !== ef || dq_oe !== 1'b1 || dbi_oe !== 1'b0)
    begin
      error_cnt++;
      $display("Error at %0t: data %h %h, want %h %h", $time, dq_rise, dq_fall, er, ef);
    end
  endtask
  task automatic wait_mode(logic lvl);
    repeat (2 * MODC + 2) @(posedge lnk_clk);
    for (int i = 0; i < 20 && mode_on !== lvl; i++)
      @(posedge lnk_clk);
    chk_bit(mode_on, lvl, "mode flag");
  endtask
  task automatic do_row(logic [8:0] r);
    int          h;
    logic [15:0] er;
    logic [15:0] ef;
    h = r[2] ? 4 : 0;
    u_prs_ctl_model.send(1'b0, 3'h0, 2'h0, {16'h0, r[1:0]});
    u_prs_ctl_model.send(1'b0, 3'h3, 2'h0, {5'h0, r[8:7], 8'h0, 1'b1, r[6:5]});
    wait_mode(1'b1);
    // A12 high, A10 set, nibble start zero
    u_prs_ctl_model.send(1'b1, 3'h0, r[4:3], {15'h0280, r[2], 2'h0});
    #1;
    chk_bit(rd_err, 1'b0, "clean read flag");
    repeat (RL - 1) @(posedge lnk_clk);
    #1;
    chk_bit(dqs_oe & ~dqs_run, 1'b1, "preamble");
    for (int p = 0; p < 4; p++)
    begin
      @(posedge lnk_clk);
      #1;
      er = lanes(r, 2 * p + h);
      ef = lanes(r, 2 * p + 1 + h);
      if (p < 2 || r[1:0] != 2'h2)
        chk_pair(er, ef);
      else
        chk_bit(dq_oe, 1'b0, "chopped tail");
    end
    @(posedge lnk_clk);
    #1;
    chk_bit(dq_oe | dqs_oe, 1'b0, "lanes after burst");
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    pg0_wr_vld = 1'b0;
    pg0_wr_loc = 2'h0;
    pg0_wr_data = 8'h00;
    ro_pages = 96'h0ff069a5_c33c817e_12e4b7d8;
    pg0_ref = '{8'h55, 8'h33, 8'h0f, 8'h00};
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge ref_clk);
    chk_bit(dq_oe | dqs_oe | dbi_oe | mode_on | array_rd | rd_err | mode_on_ref, 1'b0, "reset");
    rst <= 1'b0;
    $display("Reset done");
    // Idle time stands in for loop lock and precharge before the first entry
    repeat (20) @(posedge lnk_clk);
    foreach (rows[i])
    begin
      do_row(rows[i]);
      $display("Row %0d done", i);
    end
    // Page 0 rewrite must be read back
    @(posedge ref_clk);
    pg0_wr_vld <= 1'b1;
    pg0_wr_loc <= 2'h2;
    pg0_wr_data <= 8'hc6;
    @(posedge ref_clk);
    pg0_wr_vld <= 1'b0;
    pg0_ref[2] = 8'hc6;
    repeat (30) @(posedge lnk_clk);
    do_row(9'h010);
    $display("Page 0 rewrite done");
    // Reads at the short spacing on page 0 run seamless, unflagged
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h0, 18'h01400);
    repeat (2) @(posedge lnk_clk);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h1, 18'h01400);
    #1;
    n = 4 * rd_err;
    repeat (RL + 6)
    begin
      @(posedge lnk_clk);
      #1;
      n += dq_oe + 4 * rd_err;
    end
    chk_bit(n == 8, 1'b1, "seamless burst count");
    $display("Seamless reads done");
    // Broken address fields are still answered but flagged
    foreach (rows[i])
      if (i < 2)
      begin
        u_prs_ctl_model.send(1'b1, 3'h0, 2'h0, i ? 18'h01404 : 18'h01401);
        #1;
        chk_bit(rd_err, 1'b1, "bad address flag");
        repeat (RL + 6) @(posedge lnk_clk);
      end
    $display("Flagged reads done");
    // Page 1 with the long preamble: long spacing clean, short spacing flagged
    u_prs_ctl_model.send(1'b0, 3'h4, 2'h0, 18'h00800);
    u_prs_ctl_model.send(1'b0, 3'h3, 2'h0, 18'h00005);
    wait_mode(1'b1);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h1, 18'h01400);
    repeat (4) @(posedge lnk_clk);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h2, 18'h01400);
    #1;
    chk_bit(rd_err, 1'b0, "long spacing flag");
    repeat (3) @(posedge lnk_clk);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h3, 18'h01400);
    #1;
    chk_bit(rd_err, 1'b1, "short spacing flag");
    repeat (RL + 6) @(posedge lnk_clk);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h0, 18'h01400);
    repeat (RL - 2) @(posedge lnk_clk);
    #1;
    chk_bit(dqs_oe & ~dqs_run, 1'b1, "long preamble");
    repeat (RL + 6) @(posedge lnk_clk);
    $display("Page 1 spacing done");
    // After exit a read goes to the array and no data comes back
    u_prs_ctl_model.send(1'b0, 3'h3, 2'h0, 18'h00000);
    wait_mode(1'b0);
    u_prs_ctl_model.send(1'b1, 3'h0, 2'h0, 18'h01400);
    #1;
    chk_bit(array_rd, 1'b1, "array read");
    n = 0;
    repeat (RL + 5)
    begin
      @(posedge lnk_clk);
      #1;
      n += dq_oe;
    end
    chk_bit(n == 0 && mode_on_ref === 1'b0, 1'b1, "no data after exit");
    $display("Exit done");
    wrap_up();
  end
endmodule
`default_nettype wire
